// ### tim_map.svh
// Purpose: Register offsets, field positions and reset values of the two-channel timer
// Assumes: APB byte addresses, one 8-bit register per aligned 32-bit word
// Notes:   Definitions only
`ifndef TIM_MAP_SVH
`define TIM_MAP_SVH

// Register byte addresses
`define TIM_A_CTRL      8'h00
`define TIM_A_CNT_HI    8'h04
`define TIM_A_CNT_LO    8'h08
`define TIM_A_MOD_HI    8'h0C
`define TIM_A_MOD_LO    8'h10
`define TIM_A_CH0_CS    8'h14
`define TIM_A_CH0_VHI   8'h18
`define TIM_A_CH0_VLO   8'h1C
`define TIM_A_CH1_CS    8'h28
`define TIM_A_CH1_VHI   8'h2C
`define TIM_A_CH1_VLO   8'h30
`define TIM_A_IRQ       8'h34

// Timer control/status fields
`define TIM_B_OVF       7
`define TIM_B_OVF_IE    6
`define TIM_B_HALT      5
`define TIM_B_CLEAR     4
`define TIM_CTRL_RST    8'h20
`define TIM_MOD_RST     16'hFFFF
`define TIM_PS_EXT      3'h7

// Channel control/status fields
`define TIM_B_CH_FLAG   7
`define TIM_B_CH_IE     6
`define TIM_B_CH_MSB    5
`define TIM_B_CH_MSA    4
`define TIM_B_CH_ELB    3
`define TIM_B_CH_ELA    2
`define TIM_B_CH_TOV    1
`define TIM_B_CH_MAX    0

`endif

// ### tim_pkg.sv
// Purpose: Types shared by the timer design files
// Assumes: Nothing
// Notes:   Constants live in tim_map.svh
package tim_pkg;
	typedef logic [15:0] count_t;
	typedef logic [7:0]  byte_t;
	typedef enum logic [2:0] {
		MODE_PRESET  = 3'b001,
		MODE_CAPTURE = 3'b010,
		MODE_COMPARE = 3'b100
	} chan_mode_t;
endpackage

// ### tim_prescaler.sv
// Purpose: Tick source for the timer counter
// Assumes: External clock pin is asynchronous to i_ref_clk
// Notes:   Divider restarts on counter clear so the next tick is a full period
`timescale 1ns/10ps
`default_nettype none
`include "tim_map.svh"
module tim_prescaler #(
	parameter bit EXT_CLK_EN = 1'b1
) (
	// Clock and reset
	input  wire logic       i_ref_clk,
	input  wire logic       i_reset,
	// Control
	input  wire logic [2:0] i_prescale_select,
	input  wire logic       i_clear,
	input  wire logic       i_ext_clk,
	// Tick
	output logic            o_tick
);
	logic [5:0] div_r;
	logic [5:0] div_nxt;
	logic       ext_s1_r;
	logic       ext_s2_r;
	logic       ext_d_r;
	logic [5:0] mask;
	wire        ext_rise;
	wire        int_tick;

	assign mask     = 6'((7'h01 << i_prescale_select) - 7'h01);
	assign int_tick = (div_r & mask) == mask;
	assign ext_rise = ext_s2_r & ~ext_d_r;
	assign div_nxt  = i_clear ? 6'h00 : div_r + 6'h01;
	// code 111 uses the synchronised external clock, else bus clock / 2^code
	assign o_tick   = ~i_clear & ((i_prescale_select == `TIM_PS_EXT) ?
		(EXT_CLK_EN & ext_rise) : int_tick);

	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			div_r    <= 6'h00;
			ext_s1_r <= 1'b0;
			ext_s2_r <= 1'b0;
			ext_d_r  <= 1'b0;
		end else begin
			div_r    <= div_nxt;
			ext_s1_r <= i_ext_clk;
			ext_s2_r <= ext_s1_r;
			ext_d_r  <= ext_s2_r;
		end
	end
endmodule // tim_prescaler
`default_nettype wire

// ### tim_top.sv
// Purpose: Two-channel 16-bit timer with capture, compare and PWM, APB slave
// Assumes: Pins are asynchronous and pass two flip-flops; APB never waits
// Notes:   Each register is one byte in the low bits of an aligned word
//
// Implementation choice: register access over APB.
`timescale 1ns/10ps
`default_nettype none
`include "tim_map.svh"

// What this block does
// - Overflow flag sets when counter ticks past modulo; reset clears it.
// - Overflow flag clears by read-with-set then write zero; new overflow wins.
// - Overflow interrupt asserts while flag and enable are both one.
// - Halt bit freezes the counter; reset sets it.
// - Clear bit zeroes counter and prescaler, self-clears, reads zero.
// - Halt and clear together leave counter stopped at zero.
// - Prescale code picks bus clock divided 1..64, or external clock.
// - Reading counter high byte latches low byte until low is read.
// - Counter bytes read zero after reset and after clear.
// - On the tick after modulo the flag sets and count restarts at zero together.
// - Modulo high write blocks overflow flag until low written; reset all ones.
// - Channel flag sets on active capture edge or on compare match.
// - Channel flag clears by read-with-set then write zero; new event wins.
// - Channel interrupt asserts while its flag and enable are one.
// - Pair link bit on channel 0 links channels, disables channel 1.
// - Edge/level zero leaves pin to port; mode bit picks preset level.
// - Capture mode edge code: 01 rising, 10 falling, 11 both.
// - Compare match action: 01 toggle, 10 clear, 11 set.
// - Toggle-on-wrap inverts compare output at overflow; ignored in capture.
// - Overflow action beats compare action when both occur.
// - Full duty force with toggle-on-wrap gives 100% from next period.
// - Value high access blocks capture or compare until low accessed.
// - Linked pair: last written channel takes over at each overflow.
module tim_top
	import tim_pkg::*;
#(
	parameter bit EXT_CLK_EN = 1'b1
) (
	// Clock and reset
	input  wire logic        i_ref_clk,
	input  wire logic        i_reset,
	// APB slave
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [7:0]  i_paddr,
	input  wire logic [31:0] i_pwdata,
	output logic             o_pready,
	output logic             o_pslverr,
	output logic [31:0]      o_prdata,
	// Timer pins
	input  wire logic        i_external_timer_clock,
	input  wire logic [1:0]  i_channel_pin,
	output logic      [1:0]  o_channel_pin,
	output logic      [1:0]  o_channel_pin_oe,
	// Interrupt requests
	output logic             o_overflow_irq,
	output logic      [1:0]  o_channel_irq
);
	import tim_pkg::*;

	// Timer control and counter
	logic       overflow_flag_r;
	logic       overflow_irq_enable_r;
	logic       counter_halt_r;
	logic [2:0] prescale_select_r;
	count_t     count_r;
	count_t     modulo_r;
	byte_t      mod_hi_buf_r;
	logic       mod_wr_pend_r;
	byte_t      cnt_lo_latch_r;
	logic       cnt_latched_r;
	logic       ovf_armed_r;
	// Channel state
	byte_t      ch_cs_r [2];
	count_t     ch_val_r [2];
	byte_t      ch_hi_buf_r [2];
	logic [1:0] ch_block_r;
	logic [1:0] ch_armed_r;
	logic [1:0] ch_out_r;
	logic [1:0] pin_s1_r;
	logic [1:0] pin_s2_r;
	logic [1:0] pin_d_r;
	logic [1:0] max_r;
	logic       active_ch_r;
	logic       pend_ch_r;
	byte_t      rdata_r;

	// Bus decode
	wire        access   = i_psel & i_penable;
	wire        wr       = access & i_pwrite;
	wire        rd       = access & ~i_pwrite;
	wire byte_t wd       = i_pwdata[7:0];
	wire        sel_ctrl = i_paddr == `TIM_A_CTRL;
	wire        sel_chi  = i_paddr == `TIM_A_CNT_HI;
	wire        sel_clo  = i_paddr == `TIM_A_CNT_LO;
	wire        sel_mhi  = i_paddr == `TIM_A_MOD_HI;
	wire        sel_mlo  = i_paddr == `TIM_A_MOD_LO;
	wire        sel_irq  = i_paddr == `TIM_A_IRQ;
	wire [1:0]  sel_cs   = {i_paddr == `TIM_A_CH1_CS,  i_paddr == `TIM_A_CH0_CS};
	wire [1:0]  sel_vhi  = {i_paddr == `TIM_A_CH1_VHI, i_paddr == `TIM_A_CH0_VHI};
	wire [1:0]  sel_vlo  = {i_paddr == `TIM_A_CH1_VLO, i_paddr == `TIM_A_CH0_VLO};
	wire        mapped   = sel_ctrl | sel_chi | sel_clo | sel_mhi | sel_mlo | sel_irq |
		(|sel_cs) | (|sel_vhi) | (|sel_vlo);

	// Counter
	wire        linked   = ch_cs_r[0][`TIM_B_CH_MSB];
	wire        clr_req  = wr & sel_ctrl & wd[`TIM_B_CLEAR];
	logic       tick;
	wire        run_tick = tick & ~counter_halt_r;
	wire        at_mod   = count_r == modulo_r;
	wire        wrap     = run_tick & at_mod;
	// overflow flag held off while a modulo high write is pending
	wire        ovf_set  = wrap & ~mod_wr_pend_r;
	wire        ovf_clr  = wr & sel_ctrl & ~wd[`TIM_B_OVF] & ovf_armed_r;

	tim_prescaler #(
		.EXT_CLK_EN(EXT_CLK_EN)
	) u_prescaler (
		.i_ref_clk        (i_ref_clk),
		.i_reset          (i_reset),
		.i_prescale_select(prescale_select_r),
		.i_clear          (clr_req),
		.i_ext_clk        (i_external_timer_clock),
		.o_tick           (tick)
	);

	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			overflow_flag_r       <= 1'b0;
			overflow_irq_enable_r <= 1'b0;
			counter_halt_r        <= 1'b1;
			prescale_select_r     <= 3'h0;
			count_r               <= 16'h0000;
			modulo_r              <= `TIM_MOD_RST;
			mod_hi_buf_r          <= 8'hFF;
			mod_wr_pend_r         <= 1'b0;
			cnt_lo_latch_r        <= 8'h00;
			cnt_latched_r         <= 1'b0;
			ovf_armed_r           <= 1'b0;
		end else begin
			// Set beats clear so an overflow is never lost
			if (ovf_set)
				overflow_flag_r <= 1'b1;
			else if (ovf_clr)
				overflow_flag_r <= 1'b0;
			if (ovf_set | ovf_clr)
				ovf_armed_r <= 1'b0;
			else if (rd & sel_ctrl & overflow_flag_r)
				ovf_armed_r <= 1'b1;
			if (wr & sel_ctrl) begin
				overflow_irq_enable_r <= wd[`TIM_B_OVF_IE];
				counter_halt_r        <= wd[`TIM_B_HALT];
				prescale_select_r     <= wd[2:0];
			end
			// clear wins over counting; halt written alongside keeps zero
			if (clr_req)
				count_r <= 16'h0000;
			else if (wrap)
				count_r <= 16'h0000;
			else if (run_tick)
				count_r <= count_r + 16'h0001;
			if (wr & sel_mhi) begin
				mod_hi_buf_r  <= wd;
				mod_wr_pend_r <= 1'b1;
			end else if (wr & sel_mlo) begin
				modulo_r      <= {mod_hi_buf_r, wd};
				mod_wr_pend_r <= 1'b0;
			end
			// first high read latches low byte; low read releases it
			if (rd & sel_chi & ~cnt_latched_r) begin
				cnt_lo_latch_r <= count_r[7:0];
				cnt_latched_r  <= 1'b1;
			end else if ((rd & sel_clo) | clr_req) begin
				cnt_latched_r  <= 1'b0;
			end
		end
	end

	// Channels
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_ch
			wire byte_t cs      = ch_cs_r[g];
			wire [1:0]  el      = cs[`TIM_B_CH_ELB:`TIM_B_CH_ELA];
			// channel 1 idles while the pair is linked
			wire        dis     = (g == 1) & linked;
			wire        buffered = (g == 0) & linked;
			wire chan_mode_t mode = (el == 2'b00) ? MODE_PRESET :
				(buffered | cs[`TIM_B_CH_MSA]) ? MODE_COMPARE : MODE_CAPTURE;
			wire        rise    = pin_s2_r[g] & ~pin_d_r[g];
			wire        fall    = ~pin_s2_r[g] & pin_d_r[g];
			// edge code picks rising, falling or both
			wire        edge_hit = (el[0] & rise) | (el[1] & fall);
			wire        cap     = ~dis & (mode == MODE_CAPTURE) & edge_hit & ~ch_block_r[g];
			// in linked mode the active channel's value drives channel 0
			wire count_t cmp_val = buffered ? ch_val_r[active_ch_r] : ch_val_r[g];
			wire        cmp     = ~dis & (mode == MODE_COMPARE) & run_tick &
				(count_r == cmp_val) & ~ch_block_r[g];
			wire        ev      = cap | cmp;
			wire        fclr    = wr & sel_cs[g] & ~wd[`TIM_B_CH_FLAG] & ch_armed_r[g];
			wire        tov     = cs[`TIM_B_CH_TOV] & (mode == MODE_COMPARE);
			logic       out_nxt;

			always_comb begin
				out_nxt = ch_out_r[g];
				if (mode == MODE_PRESET)
					out_nxt = ~cs[`TIM_B_CH_MSA];
				else if (tov & wrap)
					out_nxt = max_r[g] ? 1'b1 : ~ch_out_r[g];
				else if (cmp & ~(tov & max_r[g]))
					unique case (el)
						2'b01:   out_nxt = ~ch_out_r[g];
						2'b10:   out_nxt = 1'b0;
						default: out_nxt = 1'b1;
					endcase
			end

			always_ff @(posedge i_ref_clk) begin
				if (i_reset) begin
					ch_cs_r[g]     <= 8'h00;
					ch_val_r[g]    <= 16'h0000;
					ch_hi_buf_r[g] <= 8'h00;
					ch_block_r[g]  <= 1'b0;
					ch_armed_r[g]  <= 1'b0;
					ch_out_r[g]    <= 1'b0;
					max_r[g]       <= 1'b0;
					pin_s1_r[g]    <= 1'b0;
					pin_s2_r[g]    <= 1'b0;
					pin_d_r[g]     <= 1'b0;
				end else begin
					pin_s1_r[g] <= i_channel_pin[g];
					pin_s2_r[g] <= pin_s1_r[g];
					pin_d_r[g]  <= pin_s2_r[g];
					ch_out_r[g] <= out_nxt;
					if (wrap)
						max_r[g] <= cs[`TIM_B_CH_MAX];
					if (wr & sel_cs[g] & ~dis) begin
						ch_cs_r[g][6:0] <= (g == 0) ? wd[6:0] :
							{wd[6], 1'b0, wd[4:0]};
					end
					// event wins over the clearing write
					if (ev)
						ch_cs_r[g][`TIM_B_CH_FLAG] <= 1'b1;
					else if (fclr)
						ch_cs_r[g][`TIM_B_CH_FLAG] <= 1'b0;
					if (ev | fclr)
						ch_armed_r[g] <= 1'b0;
					else if (rd & sel_cs[g] & cs[`TIM_B_CH_FLAG])
						ch_armed_r[g] <= 1'b1;
					if (cap)
						ch_val_r[g] <= count_r;
					else if (wr & sel_vlo[g])
						ch_val_r[g] <= {ch_hi_buf_r[g], wd};
					if (wr & sel_vhi[g])
						ch_hi_buf_r[g] <= wd;
					// capture: high read blocks; compare: high write blocks
					if ((mode == MODE_CAPTURE) ? (rd & sel_vhi[g]) : (wr & sel_vhi[g]))
						ch_block_r[g] <= 1'b1;
					else if ((mode == MODE_CAPTURE) ? (rd & sel_vlo[g]) : (wr & sel_vlo[g]))
						ch_block_r[g] <= 1'b0;
				end
			end

			// pin left to port while edge/level is zero; capture drives nothing
			assign o_channel_pin[g]    = ch_out_r[g];
			assign o_channel_pin_oe[g] = ~dis & (mode == MODE_COMPARE);
			assign o_channel_irq[g]    = cs[`TIM_B_CH_FLAG] & cs[`TIM_B_CH_IE];
		end
	endgenerate

	// Linked-pair ownership
	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			active_ch_r <= 1'b0;
			pend_ch_r   <= 1'b0;
		end else begin
			if (wr & (sel_vlo[1] | sel_vhi[1]))
				pend_ch_r <= 1'b1;
			else if (wr & (sel_vlo[0] | sel_vhi[0]))
				pend_ch_r <= 1'b0;
			if (~linked)
				active_ch_r <= 1'b0;
			else if (wrap)
				active_ch_r <= pend_ch_r;
		end
	end

	assign o_overflow_irq = overflow_flag_r & overflow_irq_enable_r;

	// Read mux
	byte_t rd_mux;
	always_comb begin
		rd_mux = 8'h00;
		if (sel_ctrl)
			rd_mux = {overflow_flag_r, overflow_irq_enable_r, counter_halt_r,
				1'b0, 1'b0, prescale_select_r};
		else if (sel_chi)
			rd_mux = count_r[15:8];
		else if (sel_clo)
			rd_mux = cnt_latched_r ? cnt_lo_latch_r : count_r[7:0];
		else if (sel_mhi)
			rd_mux = modulo_r[15:8];
		else if (sel_mlo)
			rd_mux = modulo_r[7:0];
		else if (sel_irq)
			rd_mux = {5'h00, o_channel_irq, o_overflow_irq};
		else if (sel_cs[0])
			rd_mux = ch_cs_r[0];
		else if (sel_cs[1])
			rd_mux = linked ? 8'h00 : ch_cs_r[1];
		else if (sel_vhi[0])
			rd_mux = ch_val_r[0][15:8];
		else if (sel_vlo[0])
			rd_mux = ch_val_r[0][7:0];
		else if (sel_vhi[1])
			rd_mux = ch_val_r[1][15:8];
		else if (sel_vlo[1])
			rd_mux = ch_val_r[1][7:0];
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_reset)
			rdata_r <= 8'h00;
		else if (i_psel & ~i_penable)
			rdata_r <= rd_mux;
	end

	// Zero-wait slave; read data is sampled in setup so side effects land on access
	assign o_pready  = 1'b1;
	assign o_pslverr = access & ~mapped;
	assign o_prdata  = {24'h000000, rdata_r};
endmodule // tim_top
`default_nettype wire

// ### tim_top_props.sv
// Purpose: Port assertions for tim_top
// Assumes: Zero-wait APB slave as handed over
// Notes:   Bound from the bench file
`timescale 1ns/10ps
`default_nettype none
`include "tim_map.svh"
module tim_props (
	// Clock and reset
	input wire logic        i_ref_clk,
	input wire logic        i_reset,
	// APB
	input wire logic        i_psel,
	input wire logic        i_penable,
	input wire logic        i_pwrite,
	input wire logic [7:0]  i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic        o_pready,
	input wire logic        o_pslverr,
	input wire logic [31:0] o_prdata,
	// Pins and requests
	input wire logic        i_external_timer_clock,
	input wire logic [1:0]  i_channel_pin,
	input wire logic [1:0]  o_channel_pin,
	input wire logic [1:0]  o_channel_pin_oe,
	input wire logic        o_overflow_irq,
	input wire logic [1:0]  o_channel_irq
);
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_reset);
	wire logic acc = i_psel && i_penable;
	wire logic rd  = acc && !i_pwrite;
	wire logic wr  = acc && i_pwrite;
	chk_ready_high: assert property (o_pready) else $error("pready low");
	chk_err_setup: assert property (!i_penable |-> !o_pslverr) else $error("early pslverr");
	chk_err_unmapped: assert property (acc && i_paddr == 8'h20 |-> o_pslverr)
		else $error("no pslverr");
	chk_reset_quiet: assert property ($fell(i_reset) |-> !o_overflow_irq &&
		o_channel_irq == 2'h0 && o_channel_pin_oe == 2'h0) else $error("not quiet");
	chk_ovf_held: assert property (o_overflow_irq && !wr |=> o_overflow_irq)
		else $error("overflow irq dropped");
	chk_chan_held: assert property (o_channel_irq[0] && !wr |=> o_channel_irq[0])
		else $error("channel irq dropped");
	chk_clear_reads0: assert property (rd && i_paddr == `TIM_A_CTRL |->
		!o_prdata[`TIM_B_CLEAR]) else $error("clear bit read one");
	chk_link_absent: assert property (rd && i_paddr == `TIM_A_CH1_CS |-> !o_prdata[5])
		else $error("ch1 bit5 read one");
	chk_irq_status: assert property (rd && i_paddr == `TIM_A_IRQ |->
		o_prdata[0] == $past(o_overflow_irq)) else $error("irq status mismatch");
	cov_ovf: cover property (o_overflow_irq);
	cov_capture: cover property (o_channel_irq[0]);
	cov_compare: cover property (o_channel_pin[1] && o_channel_pin_oe[1]);
endmodule // tim_props
`default_nettype wire

// ### tim_top_tb.sv
// Purpose: Self-checking bench for tim_top
// Assumes: Zero-wait APB, 10 MHz clock
// Notes:   External clock input is pulsed only in the prescale test
`timescale 1ns/10ps
`default_nettype none
`include "tim_map.svh"
module tim_top_tb;
	logic        i_ref_clk, i_reset, i_psel, i_penable, i_pwrite, i_external_timer_clock;
	logic [7:0]  i_paddr;
	logic [31:0] i_pwdata, rd;
	logic [1:0]  i_channel_pin;
	wire logic   o_pready, o_pslverr, o_overflow_irq;
	wire logic [31:0] o_prdata;
	wire logic [1:0]  o_channel_pin, o_channel_pin_oe, o_channel_irq;
	logic        err;
	int          fail_count, check_count;
	tim_top tim_top_i (.i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_psel(i_psel),
		.i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
		.o_pready(o_pready), .o_pslverr(o_pslverr), .o_prdata(o_prdata),
		.i_external_timer_clock(i_external_timer_clock), .i_channel_pin(i_channel_pin),
		.o_channel_pin(o_channel_pin), .o_channel_pin_oe(o_channel_pin_oe),
		.o_overflow_irq(o_overflow_irq), .o_channel_irq(o_channel_irq));
	initial begin
		i_ref_clk = 1'b0;
		forever #50 i_ref_clk = ~i_ref_clk;
	end
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	// Request held until pready is seen high at a rising edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge i_ref_clk);
		i_psel <= 1'b1;
		i_pwrite <= w;
		i_paddr <= a;
		i_pwdata <= d;
		@(posedge i_ref_clk);
		i_penable <= 1'b1;
		n = 0;
		do begin
			@(posedge i_ref_clk);
			n++;
		end while (o_pready !== 1'b1 && n < 16);
		rd = o_prdata;
		err = o_pslverr;
		if (n >= 16) begin
			fail_count++;
			$display("[FAIL] %0t bus transfer timed out", $time);
			tally_and_finish();
		end
		i_psel <= 1'b0;
		i_penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rdx(input logic [7:0] a);
		apb(1'b0, a, 32'h0);
	endtask
	function automatic logic pick(input int s);
		return s == 0 ? o_overflow_irq : s == 1 ? o_channel_irq[0] : o_channel_pin[1];
	endfunction
	task automatic wait_hi(input int s, input int lim);
		int n;
		n = 0;
		check_count++;
		while (pick(s) !== 1'b1 && n < lim) begin
			@(negedge i_ref_clk);
			n++;
		end
		if (n >= lim) begin
			fail_count++;
			$display("[FAIL] %0t timeout waiting on %0d", $time, s);
			tally_and_finish();
		end
	endtask
	task automatic t_reset();
		logic [7:0]  a[7] = '{`TIM_A_CTRL, `TIM_A_MOD_HI, `TIM_A_MOD_LO, `TIM_A_CNT_HI,
			`TIM_A_CNT_LO, `TIM_A_CH0_CS, `TIM_A_CH1_CS};
		logic [31:0] e[7] = '{32'h20, 32'hFF, 32'hFF, 32'h0, 32'h0, 32'h0, 32'h0};
		foreach (a[i]) begin
			rdx(a[i]);
			chk(rd, e[i], "reset value");
		end
		$display("test reset done");
	endtask
	task automatic t_ovf();
		wr(`TIM_A_CTRL, 32'h30);
		wr(`TIM_A_MOD_HI, 32'h0);
		wr(`TIM_A_MOD_LO, 32'h10);
		wr(`TIM_A_MOD_HI, 32'h0);
		rdx(`TIM_A_CNT_LO);
		chk(rd, 32'h0, "halt and clear");
		wr(`TIM_A_CTRL, 32'h40);
		repeat (60) @(negedge i_ref_clk);
		chk(o_overflow_irq, 1'b0, "flag held off");
		wr(`TIM_A_MOD_LO, 32'h10);
		wait_hi(0, 40);
		wr(`TIM_A_CTRL, 32'h60);
		@(negedge i_ref_clk);
		chk(o_overflow_irq, 1'b1, "clear without read");
		rdx(`TIM_A_IRQ);
		chk(rd, 32'h1, "irq status");
		rdx(`TIM_A_CTRL);
		chk(rd, 32'hE0, "flag seen");
		wr(`TIM_A_CTRL, 32'hE0);
		@(negedge i_ref_clk);
		chk(o_overflow_irq, 1'b1, "write one");
		rdx(`TIM_A_CTRL);
		wr(`TIM_A_CTRL, 32'h60);
		@(negedge i_ref_clk);
		chk(o_overflow_irq, 1'b0, "flag cleared");
		$display("test overflow done");
	endtask
	task automatic t_presc();
		logic [15:0] c;
		int e;
		wr(`TIM_A_MOD_HI, 32'hFF);
		wr(`TIM_A_MOD_LO, 32'hFF);
		for (int p = 0; p < 7; p++) begin
			wr(`TIM_A_CTRL, 32'h30 | 32'(p));
			wr(`TIM_A_CTRL, 32'(p));
			repeat (126) @(posedge i_ref_clk);
			wr(`TIM_A_CTRL, 32'h20 | 32'(p));
			rdx(`TIM_A_CNT_HI);
			c[15:8] = rd[7:0];
			rdx(`TIM_A_CNT_LO);
			c[7:0] = rd[7:0];
			e = 128 >> p;
			chk(32'(c >= e - 1 && c <= e + 1), 32'h1, "prescaled count");
		end
		// Low byte latched while halted must survive a later run
		rdx(`TIM_A_CNT_HI);
		wr(`TIM_A_CTRL, 32'h0);
		repeat (20) @(posedge i_ref_clk);
		wr(`TIM_A_CTRL, 32'h20);
		rdx(`TIM_A_CNT_HI);
		rdx(`TIM_A_CNT_LO);
		chk(rd, {24'h0, c[7:0]}, "latched low");
		wr(`TIM_A_CTRL, 32'h30);
		rdx(`TIM_A_CNT_HI);
		chk(rd, 32'h0, "cleared high");
		rdx(`TIM_A_CTRL);
		chk(rd, 32'h20, "clear self-resets");
		// Code 111 counts synchronised rising edges of the external clock
		wr(`TIM_A_CTRL, 32'h37);
		wr(`TIM_A_CTRL, 32'h07);
		repeat (4) begin
			@(posedge i_ref_clk);
			i_external_timer_clock <= 1'b1;
			repeat (4) @(posedge i_ref_clk);
			i_external_timer_clock <= 1'b0;
			repeat (3) @(posedge i_ref_clk);
		end
		wr(`TIM_A_CTRL, 32'h27);
		rdx(`TIM_A_CNT_LO);
		chk(rd, 32'h4, "external clock count");
		$display("test prescale done");
	endtask
	task automatic t_capture();
		wr(`TIM_A_CH0_CS, 32'h44);
		@(posedge i_ref_clk);
		i_channel_pin <= 2'b01;
		wait_hi(1, 10);
		rdx(`TIM_A_CH0_CS);
		chk(rd, 32'hC4, "capture flag");
		wr(`TIM_A_CH0_CS, 32'h44);
		@(negedge i_ref_clk);
		chk(o_channel_irq, 2'b00, "flag cleared");
		@(posedge i_ref_clk);
		i_channel_pin <= 2'b00;
		repeat (8) @(negedge i_ref_clk);
		chk(o_channel_irq, 2'b00, "falling ignored");
		wr(`TIM_A_CH0_CS, 32'h48);
		@(posedge i_ref_clk);
		i_channel_pin <= 2'b01;
		repeat (8) @(negedge i_ref_clk);
		chk(o_channel_irq, 2'b00, "rising ignored");
		@(posedge i_ref_clk);
		i_channel_pin <= 2'b00;
		wait_hi(1, 10);
		$display("test capture done");
	endtask
	task automatic t_compare();
		wr(`TIM_A_CTRL, 32'h30);
		wr(`TIM_A_MOD_HI, 32'h0);
		wr(`TIM_A_MOD_LO, 32'h10);
		wr(`TIM_A_CH1_VHI, 32'h0);
		wr(`TIM_A_CH1_VLO, 32'h5);
		// Preset low first, so the later set-on-compare is a real change
		wr(`TIM_A_CH1_CS, 32'h10);
		repeat (2) @(negedge i_ref_clk);
		chk(o_channel_pin[1], 1'b0, "preset low");
		chk(o_channel_pin_oe[1], 1'b0, "preset leaves pin");
		wr(`TIM_A_CH1_CS, 32'h1C);
		wr(`TIM_A_CTRL, 32'h0);
		@(negedge i_ref_clk);
		chk(o_channel_pin_oe[1], 1'b1, "compare drives pin");
		wait_hi(2, 40);
		wr(`TIM_A_CH0_CS, 32'h20);
		@(negedge i_ref_clk);
		chk(o_channel_pin_oe[1], 1'b0, "linked ch1 released");
		rdx(`TIM_A_CH1_CS);
		chk(rd, 32'h0, "ch1 status hidden");
		rdx(8'h20);
		chk({31'h0, err}, 32'h1, "unmapped error");
		chk(rd, 32'h0, "unmapped data");
		$display("test compare done");
	endtask
	// High samples of channel 0 over two periods of 17 clocks, after settling
	task automatic pwm_duty(input int e, input string m);
		int h;
		h = 0;
		repeat (40) @(negedge i_ref_clk);
		repeat (34) begin
			@(negedge i_ref_clk);
			h += (o_channel_pin[0] === 1'b1) ? 1 : 0;
		end
		chk(32'(h), 32'(e), m);
	endtask
	task automatic t_pwm();
		wr(`TIM_A_CTRL, 32'h30);
		wr(`TIM_A_CH0_VHI, 32'h0);
		wr(`TIM_A_CH0_VLO, 32'h4);
		wr(`TIM_A_CH0_CS, 32'h2A);
		wr(`TIM_A_CTRL, 32'h0);
		@(negedge i_ref_clk);
		chk(o_channel_pin_oe, 2'b01, "buffered pin driven");
		pwm_duty(10, "duty from ch0 value");
		wr(`TIM_A_CH1_VHI, 32'h0);
		wr(`TIM_A_CH1_VLO, 32'h8);
		pwm_duty(18, "duty from ch1 value");
		wr(`TIM_A_CH0_CS, 32'h2B);
		pwm_duty(34, "full duty");
		wr(`TIM_A_CH0_CS, 32'h2A);
		wr(`TIM_A_CH1_VHI, 32'h0);
		wr(`TIM_A_CH1_VLO, 32'h10);
		pwm_duty(17, "overflow beats compare");
		wr(`TIM_A_CH0_CS, 32'h28);
		pwm_duty(0, "no toggle without overflow bit");
		$display("test pwm done");
	endtask
	initial begin
		i_reset = 1'b1;
		i_psel = 1'b0;
		i_penable = 1'b0;
		i_pwrite = 1'b0;
		i_paddr = 8'h0;
		i_pwdata = 32'h0;
		i_channel_pin = 2'b00;
		i_external_timer_clock = 1'b0;
		repeat (5) @(posedge i_ref_clk);
		i_reset <= 1'b0;
		t_reset();
		t_ovf();
		t_presc();
		t_capture();
		t_compare();
		t_pwm();
		tally_and_finish();
	end
endmodule // tim_top_tb
bind tim_top tim_props tim_props_i (.i_ref_clk(i_ref_clk), .i_reset(i_reset),
	.i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
	.i_pwdata(i_pwdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .o_prdata(o_prdata),
	.i_external_timer_clock(i_external_timer_clock), .i_channel_pin(i_channel_pin),
	.o_channel_pin(o_channel_pin), .o_channel_pin_oe(o_channel_pin_oe),
	.o_overflow_irq(o_overflow_irq), .o_channel_irq(o_channel_irq));
`default_nettype wire
